// *** include/ret_exec_pkg.sv ***
// Operation
// - the immediate return puts its operand into the accumulator and then returns from the subroutine.
// - the plain return resumes at the instruction after the call that entered the routine.
// - a return first lowers the stack pointer by 2 and then loads the pc from the word it now points at.
// - the interrupt return goes back to the interrupted program and sets global interrupt enable.
// - no-operation changes nothing except advancing the pc to the next instruction.
// - watchdog clear restarts the watchdog count from its initial value.
// - none of these instructions alter the zero, carry, aux-carry or overflow flags.
// - a call stores the next address at the stack pointer, raises the pointer by 2, then jumps.
// - the unconditional jump may load any address of the whole program space.
package ret_exec_pkg;

  // ---------------------------------------------------------------
  // instruction group codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    op_nop     = 3'b000,
    op_ret     = 3'b001,
    op_ret_imm = 3'b010,
    op_reti    = 3'b011,
    op_wdreset = 3'b100,
    op_call    = 3'b101,
    op_goto    = 3'b110
  } op_t;

  // ---------------------------------------------------------------
  // execution states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_pop  = 2'b01,
    st_load = 2'b10,
    st_push = 2'b11
  } exec_state_t;

  // ---------------------------------------------------------------
  // register offsets on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] reg_ctrl = 4'h0;  // bit 0 global interrupt enable
  localparam logic [3:0] reg_sp = 4'h1;
  localparam logic [3:0] reg_acc = 4'h2;
  localparam logic [3:0] reg_flags = 4'h3;  // z, c, ac, ov in bits 0..3
  localparam logic [3:0] reg_pc_lo = 4'h4;
  localparam logic [3:0] reg_pc_hi = 4'h5;
  localparam logic [3:0] reg_status = 4'h6;  // read only: state, busy

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ctrl_gie_bit = 0;
  localparam int status_busy_bit = 2;
  localparam logic [7:0] sp_rst = 8'h00;
  localparam logic [7:0] acc_rst = 8'h00;
  localparam logic [3:0] flags_rst = 4'h0;
  localparam logic [7:0] sp_step = 8'h02;
  localparam int stack_bytes_dflt = 32;
  localparam int pc_width_dflt = 12;

endpackage

// *** rtl/ret_exec.sv ***
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module ret_exec
  import ret_exec_pkg::*;
#(
  parameter int PC_W = pc_width_dflt,
  parameter int STACK_BYTES = stack_bytes_dflt
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic [7:0] instr_imm,
  input wire logic [PC_W-1:0] instr_target,
  output logic instr_ready,
  output logic instr_done,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core state seen by the rest of the core
  output logic [PC_W-1:0] pc,
  output logic [7:0] sp,
  output logic [7:0] accumulator,
  output logic [3:0] flags,
  output logic gie,
  output logic wdt_restart
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  localparam int AW = $clog2(STACK_BYTES);

  // refused at elaboration, so a bad size never reaches simulation or a netlist
  if (PC_W < 9 || PC_W > 16) begin : g_bad_pc_w
    $error("ret_exec: PC_W must lie in 9..16");
  end
  if (STACK_BYTES < 4 || STACK_BYTES > 256 || (1 << AW) != STACK_BYTES) begin : g_bad_stack
    $error("ret_exec: STACK_BYTES must be a power of two in 4..256");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  exec_state_t state_r;
  op_t op_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] target_r;
  logic [7:0] sp_r;
  logic [7:0] acc_r;
  logic [3:0] flags_r;
  logic gie_r;
  logic wdt_r;
  logic done_r;
  logic [7:0] rdata_r;
  logic [7:0] stack_mem [STACK_BYTES];

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  logic accept;
  op_t in_op;
  logic [7:0] sp_dec;
  logic [7:0] sp_inc;
  logic [7:0] sp_next;
  logic [PC_W-1:0] pc_plus1;
  logic [15:0] pc_word;
  logic [15:0] ret_word;
  logic [AW-1:0] slot_lo;
  logic [AW-1:0] slot_hi;
  logic bus_idle_wr;

  assign in_op = op_t'(instr_op);
  assign instr_ready = (state_r == st_idle);
  assign accept = instr_valid && instr_ready;
  assign sp_dec = sp_r - sp_step;
  assign sp_inc = sp_r + sp_step;
  assign sp_next = sp_r + 8'h01;
  assign pc_plus1 = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
  assign pc_word = 16'(pc_plus1);
  // the stack wraps inside its own array; software keeps sp in range
  assign slot_lo = sp_r[AW-1:0];
  assign slot_hi = sp_next[AW-1:0];
  assign ret_word = {stack_mem[slot_hi], stack_mem[slot_lo]};
  // bus writes to pc and sp only land while no instruction owns them
  assign bus_idle_wr = reg_wr && (state_r == st_idle) && !instr_valid;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= st_idle;
      op_r <= op_nop;
      target_r <= '0;
    end else begin
      case (state_r)
        st_idle: begin
          if (accept) begin
            op_r <= in_op;
            target_r <= instr_target;
            case (in_op)
              op_ret, op_ret_imm, op_reti: state_r <= st_pop;
              op_call: state_r <= st_push;
              default: state_r <= st_idle;
            endcase
          end
        end
        st_pop: state_r <= st_load;
        st_load: state_r <= st_idle;
        st_push: state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // program counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= '0;
    end else if (accept && (in_op == op_nop || in_op == op_wdreset)) begin
      pc_r <= pc_plus1;
    end else if (accept && in_op == op_goto) begin
      pc_r <= instr_target;
    end else if (state_r == st_load) begin
      // sp already lowered in st_pop, so this is the caller's next address
      pc_r <= ret_word[PC_W-1:0];
    end else if (state_r == st_push) begin
      pc_r <= target_r;
    end else if (bus_idle_wr && reg_addr == reg_pc_lo) begin
      pc_r[7:0] <= reg_wdata;
    end else if (bus_idle_wr && reg_addr == reg_pc_hi) begin
      pc_r[PC_W-1:8] <= reg_wdata[PC_W-9:0];
    end
  end

  // ---------------------------------------------------------------
  // stack pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_r <= sp_rst;
    end else if (state_r == st_pop) begin
      sp_r <= sp_dec;
    end else if (state_r == st_push) begin
      sp_r <= sp_inc;
    end else if (bus_idle_wr && reg_addr == reg_sp) begin
      sp_r <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // stack memory, little endian word at sp
  // ---------------------------------------------------------------
  // no reset: contents are only meaningful after a call has written them
  always_ff @(posedge clk) begin
    if (state_r == st_push) begin
      stack_mem[slot_lo] <= pc_word[7:0];
      stack_mem[slot_hi] <= pc_word[15:8];
    end
  end

  // ---------------------------------------------------------------
  // accumulator
  // ---------------------------------------------------------------
  // the instruction wins over a bus write in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= acc_rst;
    end else if (accept && in_op == op_ret_imm) begin
      acc_r <= instr_imm;
    end else if (reg_wr && reg_addr == reg_acc) begin
      acc_r <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // arithmetic flags
  // ---------------------------------------------------------------
  // this group has no path into the flags; only software may write them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= flags_rst;
    end else if (reg_wr && reg_addr == reg_flags) begin
      flags_r <= reg_wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // global interrupt enable
  // ---------------------------------------------------------------
  // the set from the interrupt return wins over a software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gie_r <= 1'b0;
    end else if (state_r == st_load && op_r == op_reti) begin
      gie_r <= 1'b1;
    end else if (reg_wr && reg_addr == reg_ctrl) begin
      gie_r <= reg_wdata[ctrl_gie_bit];
    end
  end

  // ---------------------------------------------------------------
  // watchdog restart pulse and completion pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_r <= 1'b0;
    end else begin
      wdt_r <= accept && (in_op == op_wdreset);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (accept && in_op != op_ret && in_op != op_ret_imm && in_op != op_reti
                 && in_op != op_call) || state_r == st_load || state_r == st_push;
    end
  end

  // ---------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        reg_ctrl: rdata_r <= {7'h00, gie_r};
        reg_sp: rdata_r <= sp_r;
        reg_acc: rdata_r <= acc_r;
        reg_flags: rdata_r <= {4'h0, flags_r};
        reg_pc_lo: rdata_r <= pc_r[7:0];
        reg_pc_hi: rdata_r <= 8'(pc_r >> 8);
        reg_status: rdata_r <= {5'h00, state_r != st_idle, state_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign pc = pc_r;
  assign sp = sp_r;
  assign accumulator = acc_r;
  assign flags = flags_r;
  assign gie = gie_r;
  assign wdt_restart = wdt_r;
  assign instr_done = done_r;

endmodule

// *** sim/ret_exec_sva.sv ***
`timescale 1ns/1ns
module ret_exec_sva
  import ret_exec_pkg::*;
#(
  parameter int PC_W = pc_width_dflt
) (
  // clock, reset and issue
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic [7:0] instr_imm,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic instr_ready,
  input wire logic instr_done,
  // observed state
  input wire logic reg_wr,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] sp,
  input wire logic [7:0] accumulator,
  input wire logic [3:0] flags,
  input wire logic gie,
  input wire logic wdt_restart
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // accept qualifier; returns share one shape
  wire take = instr_valid && instr_ready;
  wire is_ret = instr_op == op_ret || instr_op == op_ret_imm || instr_op == op_reti;
  a_ret_sp_down: assert property (take && is_ret |-> ##2 sp == $past(sp, 2) - 8'h02)
    else $error("return did not lower sp by two");
  // the accept cycle may still carry the done pulse of the previous instruction
  a_ret_done_late: assert property (take && is_ret |=> !instr_done [*2] ##1 instr_done)
    else $error("return completion out of place");
  a_call_push: assert property (take && instr_op == op_call |->
    ##2 sp == $past(sp, 2) + 8'h02 && pc == $past(instr_target, 2))
    else $error("call did not push and jump");
  a_nop_pc_step: assert property (take && instr_op == op_nop |=> pc == $past(pc) + 1'b1)
    else $error("nop did not step pc");
  a_imm_to_acc: assert property (take && instr_op == op_ret_imm |=>
    accumulator == $past(instr_imm))
    else $error("immediate not placed in accumulator");
  a_reti_sets_gie: assert property (take && instr_op == op_reti |-> ##3 gie)
    else $error("interrupt return left gie clear");
  a_flags_kept: assert property (!reg_wr |=> flags == $past(flags))
    else $error("flags moved without a write");
  a_wdt_one_pulse: assert property (take && instr_op == op_wdreset |=>
    wdt_restart ##1 !wdt_restart)
    else $error("watchdog restart pulse wrong");
  a_goto_target: assert property (take && instr_op == op_goto |=> pc == $past(instr_target))
    else $error("jump missed its target");
endmodule

bind ret_exec ret_exec_sva #(.PC_W(PC_W)) u_sva (.clk(clk), .rst_b(rst_b),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_imm(instr_imm),
  .instr_target(instr_target), .instr_ready(instr_ready), .instr_done(instr_done),
  .reg_wr(reg_wr), .pc(pc), .sp(sp), .accumulator(accumulator), .flags(flags),
  .gie(gie), .wdt_restart(wdt_restart));

// *** sim/ret_exec_tb_top.sv ***
`timescale 1ns/1ns
module ret_exec_tb_top
  import ret_exec_pkg::*;
;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] instr_op = 3'h0;
  logic [7:0] instr_imm = 8'h00, reg_wdata = 8'h00, rd_v;
  logic [11:0] instr_target = 12'h000;
  logic [3:0] reg_addr = 4'h0;
  logic instr_ready, instr_done, gie, wdt_restart;
  logic [7:0] reg_rdata, sp, accumulator;
  logic [11:0] pc;
  logic [3:0] flags;
  logic [31:0] rnd = 32'h00014d67;
  int err_count = 0, checks = 0, m_pc = 0, m_sp = 0, m_acc = 0, m_gie = 0, m_fl = 0;
  int stk[$];

  ret_exec #(.PC_W(12), .STACK_BYTES(32)) dut (.clk(clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_imm(instr_imm),
    .instr_target(instr_target), .instr_ready(instr_ready), .instr_done(instr_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pc(pc), .sp(sp), .accumulator(accumulator), .flags(flags),
    .gie(gie), .wdt_restart(wdt_restart));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // register port: one-cycle strobes, read data the cycle after
  task automatic reg_xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  // offer one instruction, wait for done, step the model, compare
  task automatic issue(input logic [2:0] op, input logic [7:0] imm, input logic [11:0] tg);
    int n, lat;
    logic wd;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_imm <= imm;
    instr_target <= tg;
    n = 0;
    wd = 1'b0;
    do begin
      @(posedge clk);
      instr_valid <= 1'b0;
      n++;
      // look just after the edge, once the registered outputs have settled
      #1;
      if (n == 1) wd = wdt_restart;
    end while (instr_done !== 1'b1 && n < 8);
    lat = 1;
    case (op)
      op_goto: m_pc = tg;
      op_call: begin
        stk.push_back((m_pc + 1) & 'hfff);
        m_sp = (m_sp + 2) & 'hff;
        m_pc = tg;
        lat = 2;
      end
      op_ret, op_ret_imm, op_reti: begin
        m_sp = (m_sp - 2) & 'hff;
        m_pc = stk.pop_back();
        if (op == op_ret_imm) m_acc = imm;
        if (op == op_reti) m_gie = 1;
        lat = 3;
      end
      default: m_pc = (m_pc + 1) & 'hfff;
    endcase
    chk(n, lat);
    chk(32'(pc), m_pc);
    chk(32'(sp), m_sp);
    chk(32'(accumulator), m_acc);
    chk(32'(gie), m_gie);
    chk(32'(flags), m_fl);
    chk(32'(wd), 32'(op == op_wdreset));
    $display("test op %0d finished at %0t", op, $time);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    #40000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rnd = lfsr(rnd);
    m_fl = rnd[3:0];
    reg_xfer(1'b1, reg_flags, {4'h0, rnd[3:0]});
    rnd = lfsr(rnd);
    issue(op_call, 8'h00, rnd[11:0]);
    rnd = lfsr(rnd);
    issue(op_call, 8'h00, rnd[11:0]);
    rnd = lfsr(rnd);
    issue(op_ret_imm, rnd[7:0], 12'h000);
    issue(op_nop, 8'h00, 12'h000);
    issue(op_wdreset, 8'h00, 12'h000);
    issue(op_reti, 8'h00, 12'h000);
    issue(op_goto, 8'h00, 12'hfff);
    issue(op_nop, 8'h00, 12'h000);
    issue(op_call, 8'h00, 12'h800);
    issue(op_ret, 8'h00, 12'h000);
    // software moves gie, sp, pc and the accumulator between instructions
    reg_xfer(1'b1, reg_ctrl, 8'h00);
    m_gie = 0;
    reg_xfer(1'b1, reg_sp, 8'h06);
    m_sp = 6;
    reg_xfer(1'b1, reg_pc_lo, 8'h5a);
    reg_xfer(1'b1, reg_pc_hi, 8'h03);
    m_pc = 'h35a;
    reg_xfer(1'b1, reg_acc, 8'h3c);
    m_acc = 'h3c;
    rnd = lfsr(rnd);
    issue(op_call, 8'h00, rnd[11:0]);
    issue(op_reti, 8'h00, 12'h000);
    issue(op_nop, 8'h00, 12'h000);
    reg_xfer(1'b0, reg_sp, 8'h00);
    chk(32'(rd_v), m_sp);
    reg_xfer(1'b0, 4'hf, 8'h00);
    chk(32'(rd_v), 32'h0);
    reg_xfer(1'b0, reg_acc, 8'h00);
    chk(32'(rd_v), m_acc);
    reg_xfer(1'b0, reg_pc_lo, 8'h00);
    chk(32'(rd_v), m_pc & 'hff);
    reg_xfer(1'b0, reg_pc_hi, 8'h00);
    chk(32'(rd_v), m_pc >> 8);
    reg_xfer(1'b0, reg_ctrl, 8'h00);
    chk(32'(rd_v), m_gie);
    reg_xfer(1'b0, reg_flags, 8'h00);
    chk(32'(rd_v), m_fl);
    reg_xfer(1'b0, reg_status, 8'h00);
    chk(32'(rd_v), 32'h0);
    conclude();
  end
endmodule
